/* iesbw_pkg.sv */
// Shared constants for the two-wire serial EEPROM slave and its bus master.
// Assumes both ends run on one 50 MHz system clock.
package iesbw_pkg;
	// Device type code in the control byte; value is arbitrary.
	localparam logic [3:0] TYPE_CODE = 4'h6;
	// Memory organisation.
	localparam int ADDR_W = 12;
	localparam int PAGE_W = 5;
	localparam int MEM_DEPTH = 4096;
	localparam int PAGE_BYTES = 32;
	// Bit slots within a nine-clock byte frame.
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;
	// Reset levels of the synchronised pins: scl, sda high, the rest low.
	localparam logic [5:0] SYNC_RST = 6'h03;
	// Timing.
	localparam int CLK_NS = 20;
	localparam int WRITE_MS = 5;
	localparam int WRITE_CYC = WRITE_MS * 1000000 / CLK_NS;
	localparam int QUARTER_DEF = 8;
	// Controller register map.
	localparam logic [1:0] REG_CMD = 2'h0;
	localparam logic [1:0] REG_ADDR = 2'h1;
	localparam logic [1:0] REG_DATA = 2'h2;
	localparam logic [1:0] REG_STAT = 2'h3;
	// Command opcodes.
	localparam logic [1:0] OP_BYTE_WRITE = 2'h0;
	localparam logic [1:0] OP_CUR_READ = 2'h1;
	localparam logic [1:0] OP_RAND_READ = 2'h2;
endpackage

/* iesbw_if.sv */
// Two-wire link between the bus master and the EEPROM slave.
// Resolves the open-drain data line with an implied pull-up.
`timescale 1ns/1ps
interface iesbw_if;
	logic scl;
	logic sda;
	logic m_sda_o;
	logic m_sda_oe_n;
	logic d_sda_o;
	logic d_sda_oe_n;

	// The line is low when any enabled driver pulls low, otherwise pulled up.
	assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~d_sda_oe_n & ~d_sda_o));

	modport device (input scl, input sda, output d_sda_o, output d_sda_oe_n);
	modport master (output scl, input sda, output m_sda_o, output m_sda_oe_n);
endinterface

/* iesbw_device.sv */
// Slave end of the two-wire serial EEPROM: byte framing, addressing, writes.
// Assumes a master that clocks the link well below a quarter of mclk_i.
`timescale 1ns/1ps
module iesbw_device #(
	parameter int WRITE_CYCLES = iesbw_pkg::WRITE_CYC
) (
	// Link to the bus master.
	iesbw_if.device bus,
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Strap pins.
	input wire logic chip_select_in_bit0_i,
	input wire logic chip_select_in_bit1_i,
	input wire logic chip_select_in_bit2_i,
	input wire logic wp_i,
	// Status towards the read logic.
	output logic busy_o,
	output logic [iesbw_pkg::ADDR_W-1:0] addr_ptr_o
);
	import iesbw_pkg::*;
	typedef enum logic [2:0] {
		D_IDLE, D_CTRL, D_ADDRH, D_ADDRL, D_WDATA, D_READ, D_IGNORE
	} iesbw_dstate_t;
	logic [5:0] raw, filt, filt_d_reg;
	iesbw_dstate_t state_reg, nxt_reg;
	logic [3:0] cnt_reg;
	logic [7:0] shift_reg, tx_reg, rd_byte;
	logic sda_oe_n_reg, mack_reg, busy_reg;
	logic [ADDR_W-1:0] ptr_reg;
	logic [7:0] mem [MEM_DEPTH];
	logic [7:0] page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] valid_reg;
	logic [17:0] timer_reg;
	logic [5:0] wr_idx_reg;
	logic [ADDR_W-PAGE_W-1:0] page_reg;
	logic scl_f, sda_f, wp_f;
	logic [2:0] cs_f;
	logic scl_rise, scl_fall, start_ev, stop_ev;
	logic rx_state, byte_done, ctrl_match, start_wr;

	assign raw = {chip_select_in_bit2_i, chip_select_in_bit1_i, chip_select_in_bit0_i,
		wp_i, bus.sda, bus.scl};
	// Each pin passes three flops; the filtered level moves once stages two and three agree.
	for (genvar g = 0; g < 6; g++) begin : g_sync
		logic s1, s2, s3, lvl;
		always_ff @(posedge mclk_i) begin
			if (!rst_n_i) begin
				s1 <= SYNC_RST[g];
				s2 <= SYNC_RST[g];
				s3 <= SYNC_RST[g];
				lvl <= SYNC_RST[g];
			end else begin
				s1 <= raw[g];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3) begin
					lvl <= s3;
				end
			end
		end
		assign filt[g] = lvl;
	end
	// Previous filtered levels for edge finding.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			filt_d_reg <= SYNC_RST;
		end else begin
			filt_d_reg <= filt;
		end
	end
	assign scl_f = filt[0];
	assign sda_f = filt[1];
	assign wp_f = filt[2];
	assign cs_f = filt[5:3];
	assign scl_rise = scl_f & ~filt_d_reg[0];
	assign scl_fall = ~scl_f & filt_d_reg[0];
	assign start_ev = scl_f & filt_d_reg[0] & filt_d_reg[1] & ~sda_f;
	assign stop_ev = scl_f & filt_d_reg[0] & ~filt_d_reg[1] & sda_f;
	assign rx_state = (state_reg == D_CTRL) || (state_reg == D_ADDRH) ||
		(state_reg == D_ADDRL) || (state_reg == D_WDATA);
	assign byte_done = scl_fall && (cnt_reg == BIT_ACK) && rx_state;
	assign ctrl_match = (shift_reg[7:4] == TYPE_CODE) && (shift_reg[3:1] == cs_f) && !busy_reg;
	assign start_wr = stop_ev && (state_reg == D_WDATA) && (|valid_reg) && !wp_f;
	assign rd_byte = mem[ptr_reg];
	// Byte framing, acknowledge and transmit; a start or stop resets the frame at once.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_reg <= D_IDLE;
			nxt_reg <= D_IDLE;
			cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			tx_reg <= 8'h00;
			sda_oe_n_reg <= 1'b1;
			mack_reg <= 1'b0;
		end else if (start_ev || stop_ev) begin
			state_reg <= start_ev ? D_CTRL : D_IDLE;
			nxt_reg <= D_IDLE;
			cnt_reg <= 4'h0;
			sda_oe_n_reg <= 1'b1;
		end else if (scl_rise) begin
			if (cnt_reg < BIT_ACK) begin
				shift_reg <= {shift_reg[6:0], sda_f};
				cnt_reg <= cnt_reg + 4'h1;
			end else if (cnt_reg == BIT_END) begin
				mack_reg <= ~sda_f;
			end
		end else if (scl_fall) begin
			case (cnt_reg)
				BIT_ACK: begin
					cnt_reg <= BIT_END;
					nxt_reg <= state_reg;
					sda_oe_n_reg <= 1'b1;
					case (state_reg)
						D_CTRL: begin
							sda_oe_n_reg <= ~ctrl_match;
							if (!ctrl_match) begin
								nxt_reg <= D_IGNORE;
							end else if (shift_reg[0]) begin
								nxt_reg <= D_READ;
							end else begin
								nxt_reg <= D_ADDRH;
							end
						end
						D_ADDRH: begin
							sda_oe_n_reg <= 1'b0;
							nxt_reg <= D_ADDRL;
						end
						D_ADDRL: begin
							sda_oe_n_reg <= 1'b0;
							nxt_reg <= D_WDATA;
						end
						D_WDATA: begin
							sda_oe_n_reg <= 1'b0;
						end
						default: ;
					endcase
				end
				BIT_END: begin
					cnt_reg <= 4'h0;
					if ((state_reg == D_CTRL && nxt_reg == D_READ) ||
						(state_reg == D_READ && mack_reg)) begin
						state_reg <= D_READ;
						tx_reg <= rd_byte;
						sda_oe_n_reg <= rd_byte[7];
					end else begin
						state_reg <= (state_reg == D_READ) ? D_IGNORE : nxt_reg;
						sda_oe_n_reg <= 1'b1;
					end
				end
				default: begin
					if (state_reg == D_READ) begin
						tx_reg <= {tx_reg[6:0], 1'b0};
						sda_oe_n_reg <= tx_reg[6];
					end
				end
			endcase
		end
	end

	// Address pointer: loaded from the address bytes, stepped by writes and reads.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ptr_reg <= '0;
		end else if (byte_done && state_reg == D_ADDRH) begin
			ptr_reg[ADDR_W-1:8] <= shift_reg[ADDR_W-9:0];
		end else if (byte_done && state_reg == D_ADDRL) begin
			ptr_reg[7:0] <= shift_reg;
		end else if (byte_done && state_reg == D_WDATA) begin
			ptr_reg[PAGE_W-1:0] <= ptr_reg[PAGE_W-1:0] + 5'h01;
		end else if (scl_rise && cnt_reg == BIT_END && state_reg == D_READ) begin
			ptr_reg <= ptr_reg + 12'h001;
		end
	end

	// Page buffer: the newest byte for each slot overwrites the older one.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			valid_reg <= '0;
		end else if (byte_done && state_reg == D_ADDRL) begin
			valid_reg <= '0;
		end else if (byte_done && state_reg == D_WDATA) begin
			page_buf[ptr_reg[PAGE_W-1:0]] <= shift_reg;
			valid_reg[ptr_reg[PAGE_W-1:0]] <= 1'b1;
		end
	end

	// Self-timed write cycle; the whole window blocks acknowledges.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			busy_reg <= 1'b0;
			timer_reg <= '0;
			wr_idx_reg <= '0;
			page_reg <= '0;
		end else if (start_wr) begin
			busy_reg <= 1'b1;
			timer_reg <= '0;
			wr_idx_reg <= '0;
			page_reg <= ptr_reg[ADDR_W-1:PAGE_W];
		end else if (busy_reg) begin
			timer_reg <= timer_reg + 18'h0_0001;
			if (timer_reg == 18'(WRITE_CYCLES - 1)) begin
				busy_reg <= 1'b0;
			end
			wr_idx_reg <= wr_idx_reg + {5'h00, !wr_idx_reg[5]};
		end
	end

	// Array update, one page slot per cycle; stale slots keep their old value.
	always_ff @(posedge mclk_i) begin
		if (busy_reg && !wr_idx_reg[5] && valid_reg[wr_idx_reg[4:0]]) begin
			mem[{page_reg, wr_idx_reg[4:0]}] <= page_buf[wr_idx_reg[4:0]];
		end
	end

	assign bus.d_sda_o = 1'b0;
	assign bus.d_sda_oe_n = sda_oe_n_reg;
	assign busy_o = busy_reg;
	assign addr_ptr_o = ptr_reg;
endmodule

/* iesbw_master.sv */
// Bus master end: runs byte write, current read and random read sequences.
// Assumes software issues one command at a time through the register port.
`timescale 1ns/1ps
module iesbw_master #(
	parameter int QUARTER = iesbw_pkg::QUARTER_DEF
) (
	// Link to the EEPROM.
	iesbw_if.master bus,
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register port.
	input wire logic [1:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o
);
	import iesbw_pkg::*;

	typedef enum logic [1:0] {A_START, A_TX, A_RX, A_STOP} iesbw_act_t;
	typedef enum logic {M_IDLE, M_RUN} iesbw_mstate_t;

	iesbw_mstate_t state_reg;
	logic [1:0] op_reg;
	logic [2:0] cs_reg;
	logic [15:0] addr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] rx_reg;
	logic nack_reg;
	logic forced_reg;
	logic [3:0] step_reg;
	logic [1:0] ph_reg;
	logic [3:0] bitn_reg;
	logic [15:0] qcnt_reg;
	logic [7:0] sh_reg;
	logic scl_reg;
	logic oe_n_reg;
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic sda_f;
	logic go;
	iesbw_act_t cur;

	// Action of each step of each command.
	function automatic iesbw_act_t act_of(input logic [1:0] op, input logic [3:0] st);
		iesbw_act_t a;
		a = A_STOP;
		if (op == OP_BYTE_WRITE) begin
			a = (st == 4'h0) ? A_START : (st < 4'h5) ? A_TX : A_STOP;
		end else if (op == OP_CUR_READ) begin
			a = (st == 4'h0) ? A_START : (st == 4'h1) ? A_TX : (st == 4'h2) ? A_RX : A_STOP;
		end else if (st == 4'h0 || st == 4'h4) begin
			a = A_START;
		end else if (st < 4'h6) begin
			a = A_TX;
		end else if (st == 4'h6) begin
			a = A_RX;
		end
		return a;
	endfunction

	// Byte sent at each transmit step; the control byte carries the direction.
	function automatic logic [7:0] byte_of(input logic [1:0] op, input logic [3:0] st);
		logic [7:0] b;
		b = wdata_reg;
		if (st == 4'h1 || st == 4'h5) begin
			b = {TYPE_CODE, cs_reg, (op == OP_CUR_READ) || (st == 4'h5)};
		end else if (st == 4'h2) begin
			b = addr_reg[15:8];
		end else if (st == 4'h3) begin
			b = addr_reg[7:0];
		end
		return b;
	endfunction

	assign go = reg_wr_i && (reg_addr_i == REG_CMD) && (state_reg == M_IDLE);
	assign cur = forced_reg ? A_STOP : act_of(op_reg, step_reg);

	// Data line input: three flops, level accepted once the last two agree.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			sda_f <= 1'b1;
		end else begin
			s1_reg <= bus.sda;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				sda_f <= s3_reg;
			end
		end
	end

	// Command registers; writes are ignored while a command runs.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			op_reg <= OP_BYTE_WRITE;
			cs_reg <= 3'h0;
			addr_reg <= 16'h0000;
			wdata_reg <= 8'h00;
		end else if (reg_wr_i && state_reg == M_IDLE) begin
			case (reg_addr_i)
				REG_CMD: begin
					op_reg <= reg_wdata_i[1:0];
					cs_reg <= reg_wdata_i[4:2];
				end
				REG_ADDR: addr_reg <= reg_wdata_i;
				REG_DATA: wdata_reg <= reg_wdata_i[7:0];
				default: ;
			endcase
		end
	end

	// Read data, valid the cycle after the strobe.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				REG_CMD: reg_rdata_o <= {11'h000, cs_reg, op_reg};
				REG_ADDR: reg_rdata_o <= addr_reg;
				REG_DATA: reg_rdata_o <= {8'h00, rx_reg};
				default: reg_rdata_o <= {14'h0000, nack_reg, state_reg == M_RUN};
			endcase
		end else begin
			reg_rdata_o <= 16'h0000;
		end
	end

	// Bit engine: four quarter phases per bit, clock and data from flops.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_reg <= M_IDLE;
			step_reg <= 4'h0;
			ph_reg <= 2'h0;
			bitn_reg <= 4'h0;
			qcnt_reg <= 16'h0000;
			sh_reg <= 8'h00;
			scl_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			rx_reg <= 8'h00;
			nack_reg <= 1'b0;
			forced_reg <= 1'b0;
		end else if (state_reg == M_IDLE) begin
			if (go) begin
				state_reg <= M_RUN;
				step_reg <= 4'h0;
				ph_reg <= 2'h0;
				bitn_reg <= 4'h0;
				qcnt_reg <= 16'h0000;
				nack_reg <= 1'b0;
				forced_reg <= 1'b0;
			end
		end else if (qcnt_reg != 16'(QUARTER - 1)) begin
			qcnt_reg <= qcnt_reg + 16'h0001;
		end else begin
			qcnt_reg <= 16'h0000;
			ph_reg <= ph_reg + 2'h1;
			case (cur)
				A_START: begin
					// Release data, raise clock, pull data, lower clock.
					case (ph_reg)
						2'h0: oe_n_reg <= 1'b1;
						2'h1: scl_reg <= 1'b1;
						2'h2: oe_n_reg <= 1'b0;
						default: begin
							scl_reg <= 1'b0;
							step_reg <= step_reg + 4'h1;
							sh_reg <= byte_of(op_reg, step_reg + 4'h1);
						end
					endcase
				end
				A_STOP: begin
					case (ph_reg)
						2'h0: oe_n_reg <= 1'b0;
						2'h1: scl_reg <= 1'b1;
						2'h2: oe_n_reg <= 1'b1;
						default: state_reg <= M_IDLE;
					endcase
				end
				default: begin
					case (ph_reg)
						2'h0: oe_n_reg <= (bitn_reg < BIT_ACK && cur == A_TX) ? sh_reg[7] : 1'b1;
						2'h1: scl_reg <= 1'b1;
						2'h2: begin
							// A refused byte is ended by a stop after this clock pulse.
							if (bitn_reg == BIT_ACK && cur == A_TX && sda_f) begin
								nack_reg <= 1'b1;
							end
							if (bitn_reg < BIT_ACK && cur == A_RX) begin
								rx_reg <= {rx_reg[6:0], sda_f};
							end
						end
						default: begin
							scl_reg <= 1'b0;
							sh_reg <= {sh_reg[6:0], 1'b0};
							if (bitn_reg == BIT_ACK) begin
								bitn_reg <= 4'h0;
								forced_reg <= nack_reg;
								step_reg <= step_reg + 4'h1;
								sh_reg <= byte_of(op_reg, step_reg + 4'h1);
							end else begin
								bitn_reg <= bitn_reg + 4'h1;
							end
						end
					endcase
				end
			endcase
		end
	end

	assign bus.scl = scl_reg;
	assign bus.m_sda_o = 1'b0;
	assign bus.m_sda_oe_n = oe_n_reg;
endmodule

/* iesbw_properties.sv */
// Concurrent checks on the two-wire link between the bus master and the EEPROM slave.
// Assumes one system clock for both ends and a pulled-up resolved data line.
`timescale 1ns/1ps
module iesbw_properties #(
	parameter int WRITE_CYCLES = 250000
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Link signals.
	input wire logic scl,
	input wire logic sda,
	input wire logic m_sda_o,
	input wire logic m_sda_oe_n,
	input wire logic d_sda_o,
	input wire logic d_sda_oe_n,
	// Device status.
	input wire logic busy_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	int since_stop;
	int busy_cnt;

	// Counts cycles since the data line last rose while the clock was high.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			since_stop <= 1000;
		end else if (scl && $past(scl) && sda && !$past(sda)) begin
			since_stop <= 0;
		end else if (since_stop < 1000) begin
			since_stop <= since_stop + 1;
		end
	end

	// Counts the length of the current write cycle.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || !busy_o) begin
			busy_cnt <= 0;
		end else begin
			busy_cnt <= busy_cnt + 1;
		end
	end

	dev_open_drain_a: assert property (!d_sda_oe_n |-> !d_sda_o)
		else $error("device drives the data line high");
	mst_open_drain_a: assert property (!m_sda_oe_n |-> !m_sda_o)
		else $error("master drives the data line high");
	busy_no_ack_a: assert property (busy_o |-> d_sda_oe_n)
		else $error("device pulls the line during a write cycle");
	dev_change_low_a: assert property ($changed(d_sda_oe_n) |-> !scl)
		else $error("device changed the data line with the clock high");
	ack_hold_high_a: assert property ($rose(scl) && !d_sda_oe_n |-> !d_sda_oe_n [*4])
		else $error("device let go of the line during the clock high");
	drive_min_len_a: assert property ($fell(d_sda_oe_n) |-> !d_sda_oe_n [*8])
		else $error("device pulled the line for too short a time");
	stop_starts_wr_a: assert property ($rose(busy_o) |-> since_stop <= 12)
		else $error("write cycle started without a stop just before");
	write_time_a: assert property ($fell(busy_o) |->
		busy_cnt inside {[WRITE_CYCLES - 1:WRITE_CYCLES + 1]})
		else $error("write cycle length is wrong");

	// Main scenarios reached.
	start_seen_c: cover property (scl && $fell(sda));
	write_run_c: cover property ($rose(busy_o));
	dev_ack_c: cover property ($fell(d_sda_oe_n));
endmodule

/* iesbw_test.sv */
// Testbench joining the bus master and the EEPROM slave through the link interface.
// Assumes both ends share mclk_i; software reaches the master through its register port.
`timescale 1ns/1ps
module iesbw_test;
	import iesbw_pkg::*;
	localparam int WC = 600;
	localparam int WATCH_NS = 1800000;
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [1:0] reg_addr_i = 2'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic [2:0] cs_pins = 3'b101;
	logic wp_i = 1'b0;
	logic busy_o;
	logic [ADDR_W-1:0] addr_ptr_o;
	logic [15:0] rd;
	int err_count = 0;
	int compares = 0;

	iesbw_if bus_if ();

	// Both ends and the link checker.
	iesbw_master i_iesbw_master (.bus(bus_if.master), .mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
	iesbw_device #(.WRITE_CYCLES(WC)) i_iesbw_device (.bus(bus_if.device), .mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .chip_select_in_bit0_i(cs_pins[0]),
		.chip_select_in_bit1_i(cs_pins[1]), .chip_select_in_bit2_i(cs_pins[2]),
		.wp_i(wp_i), .busy_o(busy_o), .addr_ptr_o(addr_ptr_o));
	iesbw_properties #(.WRITE_CYCLES(WC)) i_iesbw_properties (.mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .scl(bus_if.scl), .sda(bus_if.sda), .m_sda_o(bus_if.m_sda_o),
		.m_sda_oe_n(bus_if.m_sda_oe_n), .d_sda_o(bus_if.d_sda_o),
		.d_sda_oe_n(bus_if.d_sda_oe_n), .busy_o(busy_o));

	// System clock of 50 MHz.
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Compares a register-width value.
	task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	// Compares a single flag.
	task automatic cmp_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	// One-cycle register write.
	task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask

	// One-cycle register read; data is taken in the following cycle.
	task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask

	// Runs one command to completion and checks its acknowledge status.
	task automatic xfer(input logic [1:0] op, input logic [2:0] cs, input logic [15:0] addr,
		input logic [7:0] data, input logic exp_nack);
		int n;
		logic [15:0] stat;
		reg_write(REG_ADDR, addr);
		reg_write(REG_DATA, {8'h00, data});
		reg_write(REG_CMD, {11'h000, cs, op});
		n = 0;
		stat = 16'h0001;
		while (stat[0] !== 1'b0 && n < 5000) begin
			reg_read(REG_STAT, stat);
			n++;
		end
		cmp_reg(stat, {14'h0000, exp_nack, 1'b0});
	endtask

	// Waits a bounded time for the write-cycle flag to reach a level.
	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy_o !== lvl && n < 2000) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		cmp_bit(busy_o, lvl);
	endtask

	// Main sequence.
	initial begin
		repeat (4) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (10) @(posedge mclk_i);
		xfer(OP_BYTE_WRITE, 3'b101, 16'h00A6, 8'hC3, 1'b0);
		wait_busy(1'b1);
		wait_busy(1'b0);
		cmp_reg({4'h0, addr_ptr_o}, 16'h00A7);
		xfer(OP_BYTE_WRITE, 3'b101, 16'hF0BF, 8'h5A, 1'b0);
		wait_busy(1'b1);
		xfer(OP_CUR_READ, 3'b101, 16'h0000, 8'h00, 1'b1);
		wait_busy(1'b0);
		cmp_reg({4'h0, addr_ptr_o}, 16'h00A0);
		$display("test plain_write done");
		xfer(OP_BYTE_WRITE, 3'b101, 16'h00A5, 8'h3C, 1'b0);
		wait_busy(1'b1);
		@(posedge mclk_i);
		wp_i <= 1'b1;
		wait_busy(1'b0);
		xfer(OP_BYTE_WRITE, 3'b101, 16'h00A5, 8'hFF, 1'b0);
		repeat (50) @(posedge mclk_i);
		cmp_bit(busy_o, 1'b0);
		xfer(OP_RAND_READ, 3'b101, 16'h00A5, 8'h00, 1'b0);
		reg_read(REG_DATA, rd);
		cmp_reg(rd, 16'h003C);
		cmp_bit(bus_if.sda, 1'b1);
		xfer(OP_CUR_READ, 3'b101, 16'h0000, 8'h00, 1'b0);
		reg_read(REG_DATA, rd);
		cmp_reg(rd, 16'h00C3);
		xfer(OP_RAND_READ, 3'b101, 16'hF0BF, 8'h00, 1'b0);
		reg_read(REG_DATA, rd);
		cmp_reg(rd, 16'h005A);
		$display("test protect done");
		@(posedge mclk_i);
		wp_i <= 1'b0;
		for (int s = 0; s < 8; s++) begin
			xfer(OP_BYTE_WRITE, s[2:0], 16'h00B0, {5'h00, s[2:0]}, s != 5);
			if (s == 5) begin
				wait_busy(1'b1);
				wait_busy(1'b0);
			end
		end
		xfer(OP_RAND_READ, 3'b101, 16'h00B0, 8'h00, 1'b0);
		reg_read(REG_DATA, rd);
		cmp_reg(rd, 16'h0005);
		cmp_bit(bus_if.scl & bus_if.sda, 1'b1);
		$display("test chip_select done");
		xfer(OP_BYTE_WRITE, 3'b101, 16'h0FFF, 8'h77, 1'b0);
		wait_busy(1'b1);
		wait_busy(1'b0);
		cmp_reg({4'h0, addr_ptr_o}, 16'h0FE0);
		xfer(OP_RAND_READ, 3'b101, 16'h0FFF, 8'h00, 1'b0);
		reg_read(REG_DATA, rd);
		cmp_reg(rd, 16'h0077);
		cmp_reg({4'h0, addr_ptr_o}, 16'h0000);
		$display("test wrap done");
		test_done();
	end

	// Cuts a hang short.
	initial begin
		#WATCH_NS;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done();
	end
endmodule
